// >>> common/pwm_pkg.sv
// package for the dual pulse-width generator block
// assumes a single 20 MHz clock and an apb master on the register side
package pwm_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] gen_a_ctrl_off = 8'h00;
  localparam logic [7:0] gen_a_period_off = 8'h04;
  localparam logic [7:0] gen_a_duty_off = 8'h08; // four words 08..14
  localparam logic [7:0] gen_a_count_off = 8'h18;
  localparam logic [7:0] gen_a_capture_off = 8'h1c;
  localparam logic [7:0] gen_b_ctrl_off = 8'h20;
  localparam logic [7:0] gen_b_period_off = 8'h24;
  localparam logic [7:0] gen_b_duty_off = 8'h28; // four words 28..34
  localparam logic [7:0] gen_b_count_off = 8'h38;
  localparam logic [7:0] status_off = 8'h3c;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int run_bit = 0;
  localparam int out_en_bit = 1; // 0: general timer only
  localparam int comp_bit = 2; // gen a only: complementary pair
  localparam int cap_en_bit = 3; // gen a only
  localparam int trig_en_bit = 4; // start on system timer trigger
  localparam int trig_sel_lsb = 5; // 2 bits
  localparam int cap_sel_lsb = 8; // 3 bits
  localparam int prescale_lsb = 16; // 8 bits
  localparam int dead_lsb = 24; // 8 bits

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [15:0] period_reset = 16'hffff;
  localparam logic [15:0] duty_reset = 16'h0000;

  // full 32-bit word so a bus write lands each field on its own bits
  typedef struct packed {
    logic [7:0] dead; // [31:24]
    logic [7:0] prescale; // [23:16]
    logic [4:0] spare_hi; // [15:11] unused, kept as written
    logic [2:0] cap_sel; // [10:8]
    logic spare_lo; // [7] unused, kept as written
    logic [1:0] trig_sel; // [6:5]
    logic trig_en;
    logic cap_en;
    logic comp;
    logic out_en;
    logic run;
  } gen_ctrl_s;

  // pulse-width generator status seen by the top
  typedef struct packed {
    logic [15:0] count;
    logic wrap;
    logic tick;
  } gen_state_s;

endpackage : pwm_pkg

// >>> rtl/pwm_timebase.sv
// divider plus 16-bit up counter shared by four outputs of one generator
// assumes control comes from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module pwm_timebase (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic clear,
  input wire logic [7:0] prescale,
  input wire logic [15:0] period,
  output var pwm_pkg::gen_state_s state
);

  logic [7:0] div;
  logic [7:0] next_div;
  pwm_pkg::gen_state_s next_state;

  // divider produces one tick every prescale+1 clocks
  always_comb begin
    next_div = div;
    next_state = state;
    next_state.tick = 1'b0;
    next_state.wrap = 1'b0;
    if (clear || !enable) begin
      next_div = 8'h00;
      if (clear) begin
        next_state.count = 16'h0000;
      end
    end else if (div >= prescale) begin
      next_div = 8'h00;
      next_state.tick = 1'b1;
      if (state.count >= period) begin
        next_state.count = 16'h0000;
        next_state.wrap = 1'b1;
      end else begin
        next_state.count = state.count + 16'h0001;
      end
    end else begin
      next_div = div + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div <= 8'h00;
      state <= '0;
    end else begin
      div <= next_div;
      state <= next_state;
    end
  end

  // prescale zero ticks every clock, so only a nonzero divide is checked
  a_tick_spacing: assert property (@(posedge clk) disable iff (srst)
    state.tick && enable && !clear && prescale != 8'h00 |=> !state.tick)
    else $error("tick came on back-to-back cycles without prescale zero");

endmodule : pwm_timebase
`default_nettype wire

// >>> rtl/quad_pwm.sv
// two four-output pulse-width generators with dead zone and capture
// assumes apb master on clk, pins and system timer triggers asynchronous
//
// Summary of operation
// - each generator has one shared 16-bit timer
// - each output has own 16-bit duty, pin
// - divider clocks each generator's timer
// - timer also usable as plain general timer
// - gen a outputs zero/one form complementary pair
// - dead zone length is 8-bit programmable
// - capture uses gen a counter, disables gen a outputs
// - capture pin chosen from port a pins 0-7
// - any of three system timers may trigger
`timescale 1ns/1ps
`default_nettype none
module quad_pwm (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_a_pin,
  input wire logic [2:0] sys_timer_trig,
  output logic [3:0] pwm_gen_a,
  output logic [3:0] pwm_gen_b
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  pwm_pkg::gen_ctrl_s ctrl_a, ctrl_b, next_ctrl_a, next_ctrl_b;
  logic [15:0] period_a, period_b, next_period_a, next_period_b;
  logic [15:0] duty [8];
  logic [15:0] next_duty [8];
  logic [15:0] capture, next_capture;
  logic cap_flag, next_cap_flag;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic clear_a, clear_b;
  pwm_pkg::gen_state_s st_a, st_b;

  // two-stage synchronisers for pins and triggers
  logic [7:0] pin_m, pin_s;
  logic [2:0] trg_m, trg_s, trg_d;
  logic cap_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer registered on access phase
  // ----------------------------------------------------------------
  wire access = psel && penable && !pready;
  wire wr = access && pwrite;
  wire cap_pin = pin_s[ctrl_a.cap_sel];
  wire cap_edge = ctrl_a.cap_en && cap_pin && !cap_d;
  wire [2:0] trg_rise = trg_s & ~trg_d;

  always_comb begin
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    next_period_a = period_a;
    next_period_b = period_b;
    next_duty = duty;
    next_capture = capture;
    next_cap_flag = cap_flag;
    next_prdata = 32'h0000_0000;
    next_pready = access;
    next_pslverr = 1'b0;
    clear_a = 1'b0;
    clear_b = 1'b0;
    // a system timer trigger starts a generator that waits on it
    if (ctrl_a.trig_en && trg_rise[ctrl_a.trig_sel]) begin
      next_ctrl_a.run = 1'b1;
    end
    if (ctrl_b.trig_en && trg_rise[ctrl_b.trig_sel]) begin
      next_ctrl_b.run = 1'b1;
    end
    if (wr) begin
      if (hit(paddr, pwm_pkg::gen_a_ctrl_off)) begin
        next_ctrl_a = pwdata;
      end else if (hit(paddr, pwm_pkg::gen_b_ctrl_off)) begin
        next_ctrl_b = pwdata;
      end else if (hit(paddr, pwm_pkg::gen_a_period_off)) begin
        next_period_a = pwdata[15:0];
      end else if (hit(paddr, pwm_pkg::gen_b_period_off)) begin
        next_period_b = pwdata[15:0];
      end else if (hit(paddr, pwm_pkg::gen_a_count_off)) begin
        clear_a = 1'b1;
      end else if (hit(paddr, pwm_pkg::gen_b_count_off)) begin
        clear_b = 1'b1;
      end else if (hit(paddr, pwm_pkg::status_off)) begin
        next_cap_flag = 1'b0; // write clears the capture flag
      end else begin
        next_pslverr = 1'b1;
        for (int i = 0; i < 4; i++) begin
          if (hit(paddr, pwm_pkg::gen_a_duty_off + 8'(4 * i))) begin
            next_duty[i] = pwdata[15:0];
            next_pslverr = 1'b0;
          end
          if (hit(paddr, pwm_pkg::gen_b_duty_off + 8'(4 * i))) begin
            next_duty[i + 4] = pwdata[15:0];
            next_pslverr = 1'b0;
          end
        end
      end
    end else if (access) begin
      next_pslverr = 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (hit(paddr, pwm_pkg::gen_a_duty_off + 8'(4 * i))) begin
          next_prdata = {16'h0000, duty[i]};
          next_pslverr = 1'b0;
        end
        if (hit(paddr, pwm_pkg::gen_b_duty_off + 8'(4 * i))) begin
          next_prdata = {16'h0000, duty[i + 4]};
          next_pslverr = 1'b0;
        end
      end
      if (hit(paddr, pwm_pkg::gen_a_ctrl_off)) begin
        next_prdata = ctrl_a;
        next_pslverr = 1'b0;
      end
      if (hit(paddr, pwm_pkg::gen_b_ctrl_off)) begin
        next_prdata = ctrl_b;
        next_pslverr = 1'b0;
      end
      if (hit(paddr, pwm_pkg::gen_a_period_off)) begin
        next_prdata = {16'h0000, period_a};
        next_pslverr = 1'b0;
      end
      if (hit(paddr, pwm_pkg::gen_b_period_off)) begin
        next_prdata = {16'h0000, period_b};
        next_pslverr = 1'b0;
      end
      if (hit(paddr, pwm_pkg::gen_a_count_off)) begin
        next_prdata = {16'h0000, st_a.count};
        next_pslverr = 1'b0;
      end
      if (hit(paddr, pwm_pkg::gen_b_count_off)) begin
        next_prdata = {16'h0000, st_b.count};
        next_pslverr = 1'b0;
      end
      if (hit(paddr, pwm_pkg::gen_a_capture_off)) begin
        next_prdata = {16'h0000, capture};
        next_pslverr = 1'b0;
      end
      if (hit(paddr, pwm_pkg::status_off)) begin
        next_prdata = {29'h0, st_b.wrap, st_a.wrap, cap_flag};
        next_pslverr = 1'b0;
      end
    end
    // capture latches gen a counter; a new edge beats the clear
    if (cap_edge) begin
      next_capture = st_a.count;
      next_cap_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_a <= pwm_pkg::ctrl_reset;
      ctrl_b <= pwm_pkg::ctrl_reset;
      period_a <= pwm_pkg::period_reset;
      period_b <= pwm_pkg::period_reset;
      for (int i = 0; i < 8; i++) begin
        duty[i] <= pwm_pkg::duty_reset;
      end
      capture <= 16'h0000;
      cap_flag <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
      period_a <= next_period_a;
      period_b <= next_period_b;
      duty <= next_duty;
      capture <= next_capture;
      cap_flag <= next_cap_flag;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // synchronisers: only the second stage and later are read
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_m <= 8'h00;
      pin_s <= 8'h00;
      trg_m <= 3'h0;
      trg_s <= 3'h0;
      trg_d <= 3'h0;
      cap_d <= 1'b0;
    end else begin
      pin_m <= port_a_pin;
      pin_s <= pin_m;
      trg_m <= sys_timer_trig;
      trg_s <= trg_m;
      trg_d <= trg_s;
      cap_d <= cap_pin;
    end
  end

  // ----------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------
  pwm_timebase u_base_a (
    .clk(clk),
    .srst(srst),
    .enable(ctrl_a.run),
    .clear(clear_a),
    .prescale(ctrl_a.prescale),
    .period(period_a),
    .state(st_a)
  );

  pwm_timebase u_base_b (
    .clk(clk),
    .srst(srst),
    .enable(ctrl_b.run),
    .clear(clear_b),
    .prescale(ctrl_b.prescale),
    .period(period_b),
    .state(st_b)
  );

  // ----------------------------------------------------------------
  // outputs and dead zone
  // ----------------------------------------------------------------
  logic [3:0] raw_a, raw_b, next_a, next_b;
  logic [7:0] dz, next_dz;
  logic raw_prev, next_raw_prev;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_cmp
      assign raw_a[g] = st_a.count < duty[g];
      assign raw_b[g] = st_b.count < duty[g + 4];
    end
  endgenerate

  // dead-zone counter counts divided ticks after each edge of output zero
  always_comb begin
    next_raw_prev = raw_a[0];
    next_dz = dz;
    if (raw_a[0] != raw_prev) begin
      next_dz = ctrl_a.dead;
    end else if (dz != 8'h00 && st_a.tick) begin
      next_dz = dz - 8'h01;
    end
    next_a = raw_a;
    if (ctrl_a.comp) begin
      next_a[0] = raw_a[0] && next_dz == 8'h00;
      next_a[1] = !raw_a[0] && next_dz == 8'h00;
    end
    // capture or plain timer use leaves the pins quiet
    if (!ctrl_a.out_en || ctrl_a.cap_en) begin
      next_a = 4'h0;
    end
    next_b = ctrl_b.out_en ? raw_b : 4'h0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_gen_a <= 4'h0;
      pwm_gen_b <= 4'h0;
      dz <= 8'h00;
      raw_prev <= 1'b0;
    end else begin
      pwm_gen_a <= next_a;
      pwm_gen_b <= next_b;
      dz <= next_dz;
      raw_prev <= next_raw_prev;
    end
  end

  sequence s_cap_on;
    ctrl_a.cap_en;
  endsequence

  a_capture_quiet: assert property (@(posedge clk) disable iff (srst)
    s_cap_on |=> pwm_gen_a == 4'h0)
    else $error("gen a outputs active during capture");
  a_pair_exclusive: assert property (@(posedge clk) disable iff (srst)
    !(pwm_gen_a[0] && pwm_gen_a[1] && $past(ctrl_a.comp)))
    else $error("complementary outputs high together");
  a_dead_gap: assert property (@(posedge clk)
    disable iff (srst)
    ctrl_a.comp && raw_a[0] != raw_prev && ctrl_a.dead != 8'h00
    |=> pwm_gen_a[1:0] == 2'b00)
    else $error("no dead zone after pair transition");
  a_capture_value: assert property (@(posedge clk)
    disable iff (srst)
    cap_edge |=> cap_flag && capture == $past(st_a.count))
    else $error("capture did not latch counter");
  a_trig_start: assert property (@(posedge clk) disable iff (srst)
    ctrl_b.trig_en && trg_rise[ctrl_b.trig_sel] && !wr |=> ctrl_b.run)
    else $error("trigger did not start gen b");
  a_duty_out_b: assert property (@(posedge clk) disable iff (srst)
    ctrl_b.out_en |=> pwm_gen_b[0] == $past(raw_b[0]))
    else $error("gen b output zero mismatches duty");
  a_timer_wrap: assert property (@(posedge clk) disable iff (srst)
    st_a.wrap |-> st_a.count == 16'h0000)
    else $error("gen a timer wrap without zero");
  a_apb_answer: assert property (@(posedge clk) disable iff (srst)
    psel && penable && !pready |=> pready)
    else $error("apb access not answered in one cycle");

endmodule : quad_pwm
`default_nettype wire

// >>> verification/pin_model.sv
// capture pins and system timer trigger lines facing the block
// assumes the bench calls its tasks just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input wire logic clk,
  output logic [7:0] port_a_pin,
  output logic [2:0] sys_timer_trig
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // pins rest low so every pulse gives one clean rising edge
  initial begin
    port_a_pin = 8'h00;
    sys_timer_trig = 3'h0;
  end

  // ----------------------------------------------------------------
  // pulse tasks
  // ----------------------------------------------------------------
  // four clocks high outlasts the two-flop synchroniser; slow on purpose
  task automatic pulse_pin(input int idx);
    port_a_pin[idx] <= 1'b1;
    repeat (4) @(posedge clk);
    port_a_pin[idx] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse_pin

  // one rising edge on the chosen system timer line
  task automatic pulse_trig(input int idx);
    sys_timer_trig[idx] <= 1'b1;
    repeat (4) @(posedge clk);
    sys_timer_trig[idx] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse_trig
endmodule : pin_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the dual pulse-width generator block
// assumes apb slave with one wait state and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] port_a_pin;
  logic [2:0] sys_timer_trig;
  logic [3:0] pwm_gen_a;
  logic [3:0] pwm_gen_b;
  logic [31:0] rd;
  logic [31:0] c0;
  logic err;
  int fails = 0;
  int total_checks = 0;
  int hi [4];
  int both;
  int d [4] = '{0, 3, 5, 12};

  always #25 clk = ~clk;

  quad_pwm uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_pin(port_a_pin),
    .sys_timer_trig(sys_timer_trig), .pwm_gen_a(pwm_gen_a),
    .pwm_gen_b(pwm_gen_b));

  pin_model pins (.clk(clk), .port_a_pin(port_a_pin),
    .sys_timer_trig(sys_timer_trig));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] expd);
    total_checks++;
    if (seen !== expd) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, expd, seen);
    end
  endtask : check

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] dat);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // ctrl word: dead, prescale, capture pin, trigger line, low flags
  function automatic logic [31:0] cw(input logic [7:0] dz, pre,
    input logic [2:0] cs, input logic [1:0] ts, input logic [4:0] f);
    cw = {dz, pre, 5'h00, cs, 1'b0, ts, f};
  endfunction : cw

  // high-cycle count per output over whole periods, phase independent
  task automatic measure(input logic gb, input int n);
    logic [3:0] v;
    for (int i = 0; i < 4; i++) hi[i] = 0;
    both = 0;
    repeat (n) begin
      @(posedge clk);
      v = gb ? pwm_gen_b : pwm_gen_a;
      for (int i = 0; i < 4; i++) hi[i] += v[i];
      both += v[0] & v[1];
    end
  endtask : measure

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(0, pwm_pkg::gen_a_ctrl_off, 0);
    check("ctrl a reset", rd, pwm_pkg::ctrl_reset);
    apb(0, pwm_pkg::gen_b_period_off, 0);
    check("period b reset", rd, {16'h0000, pwm_pkg::period_reset});
    apb(0, 8'h40, 32'h0000_0000);
    check("unmapped error", {31'h0, err}, 32'h1);
    // gen b: one timer, four independent duties, period 9
    apb(1, pwm_pkg::gen_b_period_off, 32'h0000_0009);
    for (int i = 0; i < 4; i++)
      apb(1, pwm_pkg::gen_b_duty_off + 8'(4 * i), 32'(d[i]));
    apb(1, pwm_pkg::gen_b_ctrl_off, cw(0, 0, 0, 0, 5'h03));
    measure(1, 20);
    for (int i = 0; i < 4; i++)
      check("gen b high", hi[i], 2 * (d[i] > 10 ? 10 : d[i]));
    // divide by two doubles every high time
    apb(1, pwm_pkg::gen_b_ctrl_off, cw(0, 8'h01, 0, 0, 5'h03));
    measure(1, 40);
    check("gen b divided", hi[2], 32'h14);
    // gen a as a plain timer: counts, outputs stay low
    apb(1, pwm_pkg::gen_a_duty_off, 32'h0000_000a);
    apb(1, pwm_pkg::gen_a_ctrl_off, cw(0, 0, 0, 0, 5'h01));
    apb(0, pwm_pkg::gen_a_count_off, 0);
    c0 = rd;
    apb(0, pwm_pkg::gen_a_count_off, 0);
    check("count a moves", {31'h0, rd !== c0}, 32'h1);
    check("gen a quiet", {28'h0, pwm_gen_a}, 32'h0);
    // complementary pair, period 19, duty 10, dead 2; out2/out3 plain
    apb(1, pwm_pkg::gen_a_duty_off + 8'h08, 32'h0000_0005);
    apb(1, pwm_pkg::gen_a_duty_off + 8'h0c, 32'h0000_0014);
    apb(1, pwm_pkg::gen_a_period_off, 32'h0000_0013);
    apb(1, pwm_pkg::gen_a_ctrl_off, cw(8'h02, 0, 0, 0, 5'h07));
    measure(0, 40);
    check("pair out0", hi[0], 32'h10);
    check("pair out1", hi[1], 32'h10);
    check("pair overlap", both, 32'h0);
    check("gen a out2", hi[2], 32'h0a);
    check("gen a out3", hi[3], 32'h28);
    // capture from every pin; a neighbour pin must not capture
    for (int i = 0; i < 8; i++) begin
      apb(1, pwm_pkg::gen_a_ctrl_off, cw(0, 0, 3'(i), 0, 5'h0b));
      apb(1, pwm_pkg::status_off, 0);
      pins.pulse_pin((i + 1) % 8);
      apb(0, pwm_pkg::status_off, 0);
      check("capture other pin", {31'h0, rd[0]}, 32'h0);
      pins.pulse_pin(i);
      apb(0, pwm_pkg::status_off, 0);
      check("capture flag", {31'h0, rd[0]}, 32'h1);
      check("gen a off", {28'h0, pwm_gen_a}, 32'h0);
    end
    // start gen b from each system timer line
    apb(1, pwm_pkg::gen_b_period_off, 32'h0000_ffff);
    for (int t = 0; t < 3; t++) begin
      apb(1, pwm_pkg::gen_b_ctrl_off, cw(0, 0, 0, 2'(t), 5'h12));
      apb(1, pwm_pkg::gen_b_count_off, 0);
      pins.pulse_trig((t + 1) % 3);
      apb(0, pwm_pkg::gen_b_count_off, 0);
      check("count b held", rd, 32'h0);
      pins.pulse_trig(t);
      apb(0, pwm_pkg::gen_b_ctrl_off, 0);
      check("trigger run", {31'h0, rd[0]}, 32'h1);
      apb(0, pwm_pkg::gen_b_count_off, 0);
      check("count b runs", {31'h0, rd != 0}, 32'h1);
    end
    // gen a waits on line two only
    apb(1, pwm_pkg::gen_a_ctrl_off, cw(0, 0, 0, 2'h2, 5'h10));
    pins.pulse_trig(1);
    apb(0, pwm_pkg::gen_a_ctrl_off, 0);
    check("gen a held", {31'h0, rd[0]}, 32'h0);
    pins.pulse_trig(2);
    apb(0, pwm_pkg::gen_a_ctrl_off, 0);
    check("gen a trigger run", {31'h0, rd[0]}, 32'h1);
    summarize();
  end
endmodule : testbench
`default_nettype wire
